// ---- hw/lemc_mode_ctrl.v ----
/*
 * mode and event controller of the lightning sensor: sequences power
 * down, calibration, listening and signal verification, classifies the
 * outcome, latches energy and distance, and drives the event request.
 * assumes the analog side reports watchdog level, classification and
 * energy as synchronous inputs, and that the host interface is outside.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"

module lemc_mode_ctrl (
    input  wire                      i_clk_sys,
    input  wire                      i_resetn,
    // host controls
    input  wire                      i_power_down,
    input  wire [`LEMC_WDTH_W-1:0]   i_wdog_threshold,
    input  wire                      i_mask_disturber,
    input  wire                      i_clear_stats,
    input  wire                      i_cause_read,
    // straps
    input  wire                      i_interface_select,
    input  wire                      i_address_select_low,
    input  wire                      i_address_select_high,
    // analog side
    input  wire [`LEMC_WDTH_W-1:0]   i_wdog_level,
    input  wire                      i_lco_settled,
    input  wire                      i_class_valid,
    input  wire                      i_class_disturber,
    input  wire                      i_noise_high,
    input  wire [`LEMC_ENERGY_W-1:0] i_energy,
    input  wire [`LEMC_DIST_W-1:0]   i_strike_dist,
    input  wire                      i_trim_done,
    input  wire                      i_trim_fail,
    // outputs, then the regulator enable pin input
    output reg  [`LEMC_MODE_W-1:0]   o_mode,
    output reg                       o_irq,
    output reg  [`LEMC_CAUSE_W-1:0]  o_cause,
    output reg  [`LEMC_ENERGY_W-1:0] o_energy,
    output reg  [`LEMC_DIST_W-1:0]   o_distance,
    output reg                       o_spi_select,
    output reg                       o_i2c_select,
    output reg  [`LEMC_ADDR_W-1:0]   o_i2c_address,
    output reg                       o_host_if_on,
    output reg                       o_analog_front_end_on,
    output reg                       o_watchdog_on,
    output reg                       o_noise_gen_on,
    output reg                       o_bias_on,
    output reg                       o_timer_rc_oscillator_on,
    output reg                       o_regulator_output_on,
    output reg                       o_cal_run,
    output reg                       o_cal_ref_lco,
    output reg                       o_cal_done,
    output reg                       o_cal_fail,
    input  wire                      i_regulator_enable_pin
);

    // ========
    // timing counts (typical values)
    localparam [`LEMC_CNT_W-1:0] CYC_LIGHT =
        (`LEMC_CLK_HZ / 1000000) * `LEMC_T_LIGHT_US;
    localparam [`LEMC_CNT_W-1:0] CYC_DIST =
        (`LEMC_CLK_HZ / 1000000) * `LEMC_T_DIST_US;
    localparam [`LEMC_CNT_W-1:0] CYC_CAL =
        (`LEMC_CLK_HZ / 1000000) * `LEMC_T_CAL_US;

    // long counts shortened in simulation
    parameter [`LEMC_CNT_W-1:0] T_LIGHT_CYC = CYC_LIGHT;
    parameter [`LEMC_CNT_W-1:0] T_DIST_CYC  = CYC_DIST;
    parameter [`LEMC_CNT_W-1:0] T_CAL_CYC   = CYC_CAL;

    // ========
    // state
    reg  [`LEMC_MODE_W-1:0]  next_mode;
    reg                      strap_taken;   // straps caught after reset
    reg                      disturber;     // unmasked disturber seen since cause read
    reg                      tmr_load;      // start hold timer
    reg  [`LEMC_CNT_W-1:0]   tmr_count;     // hold length
    reg                      cal_load;      // start calibration bound
    reg                      dist_update;   // push strike distance
    wire                     tmr_expired;   // hold period over
    wire                     tmr_busy;      // hold timer running
    wire                     cal_expired;   // calibration deadline hit
    wire                     cal_busy;      // calibration bound running
    wire [`LEMC_DIST_W-1:0]  edge_dist;     // leading edge distance
    wire                     edge_valid;    // edge distance known
    wire                     above_thresh;  // watchdog crossing
    wire                     abort;         // power down forces stop

    assign above_thresh = (i_wdog_level > i_wdog_threshold);
    assign abort        = i_power_down;

    // ========
    // verification hold timer
    lemc_timer u_hold (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_load    (tmr_load),
        .i_count   (tmr_count),
        .i_stop    (abort),
        .o_expired (tmr_expired),
        .o_busy    (tmr_busy)
    );

    // calibration deadline timer
    lemc_timer u_cal (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_load    (cal_load),
        .i_count   (T_CAL_CYC),
        .i_stop    (abort | i_trim_done | i_trim_fail),
        .o_expired (cal_expired),
        .o_busy    (cal_busy)
    );

    // leading edge tracker
    lemc_distance u_dist (
        .i_clk_sys     (i_clk_sys),
        .i_resetn      (i_resetn),
        .i_update      (dist_update),
        .i_strike_dist (i_strike_dist),
        .i_clear       (i_clear_stats),
        .o_edge_dist   (edge_dist),
        .o_valid       (edge_valid)
    );

    // ========
    // next mode and timer starts
    always @* begin
        next_mode   = o_mode;
        tmr_load    = 1'b0;
        tmr_count   = T_LIGHT_CYC;
        cal_load    = 1'b0;
        dist_update = 1'b0;
        case (o_mode)
            `LEMC_M_PWD: begin
                // only the host interface survives here
                if (!i_power_down) begin
                    next_mode = `LEMC_M_CAL;
                end
            end
            `LEMC_M_CAL: begin
                // trimming waits for the antenna oscillator
                if (i_lco_settled && !cal_busy && !o_cal_run) begin
                    cal_load = 1'b1; // R11
                end
                if (o_cal_run && (i_trim_done || i_trim_fail ||
                                  cal_expired)) begin
                    next_mode = `LEMC_M_LISTEN;
                end
            end
            `LEMC_M_LISTEN: begin
                if (above_thresh) begin
                    next_mode = `LEMC_M_VERIFY; // R1
                end
            end
            `LEMC_M_VERIFY: begin
                if (i_class_valid) begin
                    if (i_class_disturber) begin
                        // stop at once; no energy nor distance
                        next_mode = `LEMC_M_HOLD; // R2
                        tmr_load  = 1'b1;
                        tmr_count = T_DIST_CYC; // R6
                    end else begin
                        next_mode = `LEMC_M_ENERGY; // R3
                    end
                end
            end
            `LEMC_M_ENERGY: begin
                next_mode = `LEMC_M_DISTANCE; // R3
            end
            `LEMC_M_DISTANCE: begin
                dist_update = 1'b1; // R3
                next_mode   = `LEMC_M_HOLD;
                tmr_load    = 1'b1;
                tmr_count   = T_LIGHT_CYC; // R6
            end
            `LEMC_M_HOLD: begin
                if (tmr_expired) begin
                    next_mode = `LEMC_M_LISTEN; // R14
                end
            end
            default: begin
                next_mode = `LEMC_M_PWD;
            end
        endcase
        if (i_power_down) begin
            next_mode = `LEMC_M_PWD; // R9
        end
    end

    // ========
    // mode register and block enables
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_mode                   <= `LEMC_M_PWD;
            o_host_if_on             <= 1'b1;
            o_analog_front_end_on    <= 1'b0;
            o_watchdog_on            <= 1'b0;
            o_noise_gen_on           <= 1'b0;
            o_bias_on                <= 1'b0;
            o_timer_rc_oscillator_on <= 1'b0;
            o_regulator_output_on    <= 1'b0;
        end else begin
            o_mode       <= next_mode;
            o_host_if_on <= 1'b1; // R9
            // everything analog off in power down; watchdog on only in listening, the rest on otherwise, regulator only with its pin
            o_analog_front_end_on    <= (next_mode != `LEMC_M_PWD); // R10
            o_watchdog_on            <= (next_mode == `LEMC_M_LISTEN); // R10
            o_noise_gen_on           <= (next_mode != `LEMC_M_PWD); // R10
            o_bias_on                <= (next_mode != `LEMC_M_PWD); // R10
            o_timer_rc_oscillator_on <= (next_mode != `LEMC_M_PWD); // R10
            o_regulator_output_on    <= (next_mode != `LEMC_M_PWD) &&
                                        i_regulator_enable_pin; // R10
        end
    end

    // ========
    // calibration status; LC oscillator is the trim reference
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cal_run     <= 1'b0;
            o_cal_ref_lco <= 1'b0;
            o_cal_done    <= 1'b0;
            o_cal_fail    <= 1'b0;
        end else begin
            if (cal_load) begin
                o_cal_run     <= 1'b1; // R11
                o_cal_ref_lco <= 1'b1; // R12
                o_cal_done    <= 1'b0;
                o_cal_fail    <= 1'b0;
            end else if (o_cal_run) begin
                if (i_trim_done && !i_trim_fail) begin
                    o_cal_done <= 1'b1; // R12
                    o_cal_run  <= 1'b0;
                end else if (i_trim_fail || cal_expired || abort) begin
                    // deadline overrun counts as failure
                    o_cal_fail <= 1'b1; // R11
                    o_cal_run  <= 1'b0;
                end
            end
            if (!o_cal_run || !cal_load) begin
                o_cal_ref_lco <= o_cal_run && !cal_load ?
                                 o_cal_ref_lco : cal_load;
            end
        end
    end

    // ========
    // results, cause and event request
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_energy   <= {`LEMC_ENERGY_W{1'b0}};
            o_distance <= {`LEMC_DIST_W{1'b1}};
            o_cause    <= `LEMC_CAUSE_NONE;
            o_irq      <= 1'b0;
            disturber  <= 1'b0;
        end else begin
            o_distance <= edge_dist; // R5
            if (o_mode == `LEMC_M_ENERGY) begin
                o_energy <= i_energy; // R3
            end
            // a new strike or disturber wins over the host's read clear
            if (o_mode == `LEMC_M_DISTANCE) begin
                o_cause <= `LEMC_CAUSE_LIGHT; // R13
                o_irq   <= 1'b1; // R4
            end else if (o_mode == `LEMC_M_VERIFY && i_class_valid &&
                         i_class_disturber && !i_mask_disturber) begin
                o_cause   <= `LEMC_CAUSE_DIST; // R13
                o_irq     <= 1'b1;
                disturber <= 1'b1;
            end else if (i_noise_high && o_mode != `LEMC_M_PWD &&
                         !o_irq) begin
                o_cause <= `LEMC_CAUSE_NOISE; // R13
                o_irq   <= 1'b1;
            end else if (i_cause_read) begin
                o_irq     <= 1'b0;
                o_cause   <= `LEMC_CAUSE_NONE;
                disturber <= 1'b0;
            end
        end
    end

    // ========
    // straps caught once after reset release
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_taken   <= 1'b0;
            o_spi_select  <= 1'b1;
            o_i2c_select  <= 1'b0;
            o_i2c_address <= `LEMC_ADDR_BASE;
        end else if (!strap_taken) begin
            strap_taken   <= 1'b1;
            o_spi_select  <= !i_interface_select; // R7
            o_i2c_select  <= i_interface_select; // R7
            // pattern 00 is not a valid choice; it falls to 01
            o_i2c_address <= `LEMC_ADDR_BASE +
                {5'h00, (i_address_select_high | i_address_select_low)
                            ? {i_address_select_high,
                               i_address_select_low}
                            : 2'h1}; // R8
        end
    end

endmodule
`default_nettype wire

// ---- hw/lemc_consts.vh ----
/*
 * constants of the lightning event mode controller: mode codes, field
 * positions, cause codes and timing figures.
 * assumes a 40 MHz system clock and inclusion by bare name.
 */
// Overview of operation
// R1 - watchdog over threshold enters signal verification
// R2 - disturber aborts processing, returns to listening
// R3 - accepted strike computes energy, then distance
// R4 - every detected strike raises event request pin
// R5 - distance reports storm leading edge, not strike
// R6 - verification holds 1 s strike, 1.5 s disturber
// R7 - strap low selects SPI, high I2C
// R8 - two address pins choose among three addresses
// R9 - power-down keeps only the host interface
// R10 - listening keeps front end, watchdog, oscillator running
// R11 - calibration starts after LC settles, within 2 ms
// R12 - LC oscillator trims timer and system oscillators
// R13 - interrupt cause in four-bit field of 0x03
// R14 - after verification period return and rearm watchdog
`ifndef LEMC_CONSTS_VH
`define LEMC_CONSTS_VH

// ========
// register positions
`define LEMC_REG_WDOG      8'h01
`define LEMC_REG_CAUSE     8'h03
`define LEMC_WDTH_W        4
`define LEMC_CAUSE_W       4
`define LEMC_DIST_W        6
`define LEMC_ENERGY_W      21
`define LEMC_WDTH_RESET    4'h2

// ========
// interrupt cause codes
`define LEMC_CAUSE_NONE    4'h0
`define LEMC_CAUSE_NOISE   4'h1
`define LEMC_CAUSE_DIST    4'h4
`define LEMC_CAUSE_LIGHT   4'h8

// ========
// mode codes
`define LEMC_MODE_W        3
`define LEMC_M_PWD         3'h0
`define LEMC_M_CAL         3'h1
`define LEMC_M_LISTEN      3'h2
`define LEMC_M_VERIFY      3'h3
`define LEMC_M_ENERGY      3'h4
`define LEMC_M_DISTANCE    3'h5
`define LEMC_M_HOLD        3'h6

// ========
// timing: clock rate in Hz, times in microseconds
`define LEMC_CLK_HZ        40000000
`define LEMC_T_LIGHT_US    1000000
`define LEMC_T_DIST_US     1500000
`define LEMC_T_CAL_US      2000
`define LEMC_CNT_W         27
`define LEMC_ADDR_W        7
`define LEMC_ADDR_BASE     7'h00

`endif

// ---- hw/lemc_timer.v ----
/*
 * down counter that loads a cycle count and flags expiry with a pulse.
 * assumes the load and the count fit in LEMC_CNT_W bits.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"

module lemc_timer (
    input  wire                     i_clk_sys,
    input  wire                     i_resetn,
    input  wire                     i_load,
    input  wire [`LEMC_CNT_W-1:0]   i_count,
    input  wire                     i_stop,
    output reg                      o_expired,
    output reg                      o_busy
);

    reg [`LEMC_CNT_W-1:0] remain;   // cycles still to run

    // ========
    // count down, pulse once when the last cycle passes
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            remain    <= {`LEMC_CNT_W{1'b0}};
            o_busy    <= 1'b0;
            o_expired <= 1'b0;
        end else begin
            o_expired <= 1'b0;
            if (i_stop) begin
                // abort wins so that a stale expiry never escapes
                o_busy <= 1'b0;
            end else if (i_load) begin
                remain <= i_count - {{(`LEMC_CNT_W-1){1'b0}}, 1'b1};
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (remain <= {{(`LEMC_CNT_W-1){1'b0}}, 1'b1}) begin
                    o_busy    <= 1'b0;
                    o_expired <= 1'b1;
                end else begin
                    remain <= remain - {{(`LEMC_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- hw/lemc_distance.v ----
/*
 * keeps the storm's leading edge distance: the closest distance among
 * recent strikes, which only moves outward when statistics clear.
 * assumes one strike distance per i_update pulse.
 */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"

module lemc_distance (
    input  wire                     i_clk_sys,
    input  wire                     i_resetn,
    input  wire                     i_update,
    input  wire [`LEMC_DIST_W-1:0]  i_strike_dist,
    input  wire                     i_clear,
    output reg  [`LEMC_DIST_W-1:0]  o_edge_dist,
    output reg                      o_valid
);

    // ========
    // leading edge is the minimum over the storm, not the latest strike
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_edge_dist <= {`LEMC_DIST_W{1'b1}};
            o_valid     <= 1'b0;
        end else if (i_update) begin
            // update beats clear so a strike in that cycle is kept
            if (!o_valid || i_clear || i_strike_dist < o_edge_dist) begin
                o_edge_dist <= i_strike_dist; // R5
            end
            o_valid <= 1'b1;
        end else if (i_clear) begin
            o_edge_dist <= {`LEMC_DIST_W{1'b1}};
            o_valid     <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ---- verification/lemc_mode_ctrl_properties.sv ----
/* checker of the mode controller: mode order, event flag, power gating.
   assumes it is bound onto lemc_mode_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"
module lemc_mode_ctrl_props (
    input wire logic       i_clk_sys,
    input wire logic       i_resetn,
    input wire logic       i_power_down,
    input wire logic [3:0] i_wdog_threshold,
    input wire logic [3:0] i_wdog_level,
    input wire logic       i_class_valid,
    input wire logic       i_class_disturber,
    input wire logic       i_lco_settled,
    input wire logic       i_cause_read,
    input wire logic [2:0] o_mode,
    input wire logic       o_irq,
    input wire logic [3:0] o_cause,
    input wire logic       o_host_if_on,
    input wire logic       o_analog_front_end_on,
    input wire logic       o_watchdog_on,
    input wire logic       o_cal_run,
    input wire logic       o_cal_ref_lco
);
    // ========
    // one domain
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    wire logic run = !i_power_down; // power-down beats every transition
    property p_enter_verify;
        o_mode == `LEMC_M_LISTEN && i_wdog_level > i_wdog_threshold && run
            |=> o_mode == `LEMC_M_VERIFY;
    endproperty
    a_enter_verify: assert property (p_enter_verify) else $error("no verify");
    property p_abort;
        o_mode == `LEMC_M_VERIFY && i_class_valid && i_class_disturber && run
            |=> o_mode == `LEMC_M_HOLD;
    endproperty
    a_abort: assert property (p_abort) else $error("disturber not aborted");
    property p_strike_seq;
        o_mode == `LEMC_M_VERIFY && i_class_valid && !i_class_disturber && run
            |=> o_mode == `LEMC_M_ENERGY ##1 o_mode == `LEMC_M_DISTANCE
            ##1 o_mode == `LEMC_M_HOLD;
    endproperty
    a_strike_seq: assert property (p_strike_seq) else $error("bad order");
    property p_strike_irq;
        o_mode == `LEMC_M_DISTANCE && run |=> o_irq && o_cause == 4'h8;
    endproperty
    a_strike_irq: assert property (p_strike_irq) else $error("no strike irq");
    property p_pwd_gate;
        i_power_down [*2] |-> o_mode == `LEMC_M_PWD && o_host_if_on
            && !o_analog_front_end_on && !o_watchdog_on;
    endproperty
    a_pwd_gate: assert property (p_pwd_gate) else $error("power-down leak");
    property p_listen_on;
        o_mode == `LEMC_M_LISTEN [*2] |-> o_analog_front_end_on && o_watchdog_on;
    endproperty
    a_listen_on: assert property (p_listen_on) else $error("listen off");
    property p_cal_start;
        $rose(o_cal_run) |-> $past(i_lco_settled);
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("early trim");
    property p_cal_ref;
        o_cal_run |-> o_cal_ref_lco;
    endproperty
    a_cal_ref: assert property (p_cal_ref) else $error("trim without lco");
    property p_irq_stands;
        o_irq && !i_cause_read && run |=> o_irq && o_cause != 4'h0;
    endproperty
    a_irq_stands: assert property (p_irq_stands) else $error("irq dropped");
    // main scenarios reached
    c_strike: cover property (o_mode == `LEMC_M_DISTANCE);
    c_dist: cover property (i_class_valid && i_class_disturber && !o_irq);
    c_cal: cover property ($rose(o_cal_run));
endmodule
bind lemc_mode_ctrl lemc_mode_ctrl_props u_props (.i_clk_sys, .i_resetn,
    .i_power_down, .i_wdog_threshold, .i_wdog_level, .i_class_valid,
    .i_class_disturber, .i_lco_settled, .i_cause_read, .o_mode, .o_irq,
    .o_cause, .o_host_if_on, .o_analog_front_end_on, .o_watchdog_on,
    .o_cal_run, .o_cal_ref_lco);
`default_nettype wire

// ---- verification/lemc_analog_model.sv ----
/* analog side model: classification and trim-done pulses.
   assumes the controller samples on the rising edge. */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"
module lemc_analog_model #(parameter int GAP = 2) (
    input  wire logic       i_clk_sys,
    input  wire logic [2:0] i_mode,
    input  wire logic       i_cal_run,
    input  wire logic       i_disturb,
    input  wire logic       i_trim_en,
    output var  logic       o_class_valid,
    output var  logic       o_class_disturber,
    output var  logic       o_trim_done
);
    int cnt = 0; // cycles spent verifying or trimming
    // ========
    // answers GAP cycles late, changed on the falling edge
    always @(negedge i_clk_sys) begin
        cnt <= (i_mode == `LEMC_M_VERIFY || i_cal_run) ? cnt + 1 : 0;
        o_class_valid <= i_mode == `LEMC_M_VERIFY && cnt == GAP;
        o_trim_done <= i_cal_run && i_trim_en && cnt == GAP;
        // flag is junk without valid
        if (i_mode == `LEMC_M_VERIFY && cnt == GAP) begin
            o_class_disturber <= i_disturb;
        end else begin
            o_class_disturber <= (o_class_disturber !== 1'b1);
        end
    end
endmodule
`default_nettype wire

// ---- verification/lemc_mode_ctrl_tb.sv ----
/* self-checking bench of the mode controller against a bench model.
   assumes short hold and calibration counts set at the instance. */
`timescale 1ns/1ps
`default_nettype none
`include "lemc_consts.vh"
module lemc_mode_ctrl_tb;
    // ========
    // stimulus and observed ports
    localparam int TL = 20, TD = 30;
    logic i_clk_sys = 0, i_resetn = 0, i_power_down = 0, i_clear_stats = 0;
    logic i_mask_disturber = 0, i_cause_read = 0, i_interface_select = 0;
    logic i_address_select_low = 0, i_address_select_high = 0;
    logic i_lco_settled = 0, i_regulator_enable_pin = 1, dis_m = 0, trim = 1;
    logic noise = 0;
    logic [3:0] i_wdog_threshold = 4'h2, i_wdog_level = 4'h0;
    logic [20:0] i_energy = 21'h0;
    logic [5:0] i_strike_dist = 6'h0;
    wire logic i_class_valid, i_class_disturber, i_trim_done, o_irq;
    wire logic [2:0] o_mode;
    wire logic [3:0] o_cause;
    wire logic [20:0] o_energy;
    wire logic [5:0] o_distance;
    wire logic [6:0] o_i2c_address;
    wire logic o_spi_select, o_i2c_select, o_host_if_on, o_watchdog_on;
    wire logic o_analog_front_end_on, o_noise_gen_on, o_bias_on, o_cal_run;
    wire logic o_timer_rc_oscillator_on, o_regulator_output_on;
    wire logic o_cal_ref_lco, o_cal_done, o_cal_fail;
    int bad_count = 0, num_checks = 0, cycles = 0;
    int e_irq, e_cause, e_energy, e_dist, n; // bench model state
    lemc_mode_ctrl #(.T_LIGHT_CYC(27'd20), .T_DIST_CYC(27'd30),
        .T_CAL_CYC(27'd10)) u_dut (.i_clk_sys, .i_resetn, .i_power_down,
        .i_wdog_threshold, .i_mask_disturber, .i_clear_stats, .i_cause_read,
        .i_interface_select, .i_address_select_low, .i_address_select_high,
        .i_wdog_level, .i_lco_settled, .i_class_valid, .i_class_disturber,
        .i_noise_high(noise), .i_energy, .i_strike_dist, .i_trim_done,
        .i_trim_fail(1'b0), .o_mode, .o_irq, .o_cause, .o_energy, .o_distance,
        .o_spi_select, .o_i2c_select, .o_i2c_address, .o_host_if_on,
        .o_analog_front_end_on, .o_watchdog_on, .o_noise_gen_on, .o_bias_on,
        .o_timer_rc_oscillator_on, .o_regulator_output_on, .o_cal_run,
        .o_cal_ref_lco, .o_cal_done, .o_cal_fail, .i_regulator_enable_pin);
    lemc_analog_model u_afe (.i_clk_sys, .i_mode(o_mode), .i_cal_run(o_cal_run),
        .i_disturb(dis_m), .i_trim_en(trim), .o_class_valid(i_class_valid),
        .o_class_disturber(i_class_disturber), .o_trim_done(i_trim_done));
    always #12.5 i_clk_sys = ~i_clk_sys;
    // hang guard
    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            bad_count++;
            test_done();
        end
    end
    // ========
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("unexpected at %0t: saw %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge i_clk_sys);
    endtask
    task automatic wait_mode(input logic [2:0] m);
        for (int k = 0; k < 100 && o_mode !== m; k++) cyc(1);
        chk(o_mode, m);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // reset with a strap set, then calibrate into listening
    task automatic boot(input int s);
        i_resetn = 0;
        i_lco_settled = 0;
        {i_interface_select, i_address_select_high, i_address_select_low} = s;
        trim = (s != 15); // last pass misses the trim deadline
        cyc(4);
        chk({o_mode, o_irq, o_cause, o_distance, o_host_if_on, o_spi_select},
            {7'h0, 6'h3F, 2'b11});
        i_resetn = 1;
        wait_mode(`LEMC_M_CAL);
        cyc(3);
        chk(o_cal_run, 0);
        i_lco_settled = 1;
        wait_mode(`LEMC_M_LISTEN);
        chk({o_cal_done, o_cal_fail}, {s != 15, s == 15});
        chk({o_spi_select, o_i2c_select}, {~s[2], s[2]});
        chk(o_i2c_address, `LEMC_ADDR_BASE + (s[1:0] == 0 ? 1 : s[1:0]));
        {e_irq, e_cause, e_energy, e_dist} = {32'd0, 32'd0, 32'd0, 32'd63};
    endtask
    // one event and its outcome
    task automatic ev(input logic dis, input logic msk);
        logic [3:0] t;
        t = 4'($urandom_range(0, 14));
        {i_wdog_threshold, i_wdog_level, dis_m, i_mask_disturber} = {t, t, dis, msk};
        i_energy = 21'($urandom);
        i_strike_dist = 6'($urandom_range(0, 62));
        cyc(3);
        chk(o_mode, `LEMC_M_LISTEN);
        i_wdog_level = t + 4'h1;
        cyc(1);
        chk(o_mode, `LEMC_M_VERIFY);
        i_wdog_level = 4'h0;
        wait_mode(`LEMC_M_HOLD);
        if (!dis) begin
            {e_irq, e_cause, e_energy} = {32'd1, 32'd8, 11'd0, i_energy};
            if (i_strike_dist < e_dist) e_dist = i_strike_dist;
        end else if (!msk) begin
            {e_irq, e_cause} = {32'd1, 32'd4};
        end
        for (n = 0; n < 99 && o_mode === `LEMC_M_HOLD; n++) cyc(1);
        chk(n, dis ? TD : TL);
        chk(o_mode, `LEMC_M_LISTEN);
        chk({o_analog_front_end_on, o_watchdog_on, o_noise_gen_on, o_bias_on,
            o_timer_rc_oscillator_on, o_regulator_output_on}, 6'h3F);
        chk({o_irq, o_cause}, {e_irq[0], e_cause[3:0]});
        chk({o_energy, o_distance}, {e_energy[20:0], e_dist[5:0]});
    endtask
    task automatic rd_cause;
        chk(o_cause, e_cause);
        i_cause_read = 1;
        cyc(1);
        i_cause_read = 0;
        cyc(1);
        chk({o_irq, o_cause}, 5'h0);
        {e_irq, e_cause} = {32'd0, 32'd0};
    endtask
    // ========
    // main sequence
    initial begin
        void'($urandom(32'hE83C));
        for (int i = 0; i < 4; i++) begin
            boot(i * 5);
            ev(1'b0, 1'b0);
        end
        ev(1'b1, 1'b0);
        rd_cause();
        ev(1'b1, 1'b1);
        ev(1'b0, 1'b0);
        ev(1'b0, 1'b0);
        rd_cause();
        noise = 1;
        cyc(1);
        noise = 0;
        e_cause = 1;
        chk({o_irq, o_cause}, 5'h11);
        rd_cause();
        i_clear_stats = 1;
        cyc(1);
        i_clear_stats = 0;
        cyc(2);
        chk(o_distance, 6'h3F);
        {i_power_down, i_wdog_level} = 5'h1F; // events must be ignored
        cyc(4);
        chk({o_mode, o_host_if_on, o_analog_front_end_on, o_watchdog_on,
            o_bias_on, o_timer_rc_oscillator_on}, 8'h10);
        {i_power_down, i_wdog_level} = 5'h0;
        wait_mode(`LEMC_M_LISTEN);
        test_done();
    end
endmodule
`default_nettype wire
